// ==== hw/gpd_pin_config.sv ====
// Pin designation registers and pin mux for general pins 1 and 2
`timescale 1ns/1ns
module gpd_pin_config (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [7:0] store_pin1_i,
   input wire logic [7:0] store_pin2_i,
   input wire logic ref_clock_i,
   input wire logic uart_tx_activity_led_i,
   input wire logic pin2_dedicated_i,
   input wire logic pin2_alt0_i,
   input wire logic pin2_alt1_i,
   input wire logic pin1_in_i,
   input wire logic pin2_in_i,
   output logic pin1_out_o,
   output logic pin1_oe_o,
   output logic pin2_out_o,
   output logic pin2_oe_o,
   output logic irq_edge_in_o,
   output logic analog_input_ch1_o,
   output logic analog_pin2_o,
   output logic [1:0] gpio_in_o,
   output logic [7:0] store_wdata_o,
   output logic store_we1_o,
   output logic store_we2_o,
   output logic loaded_o
);
   import gpd_pkg::*;

   gpd_state_t state;
   gpd_state_t next_state;
   logic [7:0] pin1_function_setting;
   logic [7:0] pin2_function_setting;
   logic [7:0] next_pin1;
   logic [7:0] next_pin2;
   logic rd_done;
   logic [31:0] next_rdata;
   logic wr_ok;
   logic [2:0] des1;
   logic [2:0] des2;
   logic gpio1;
   logic gpio2;

   assign wr_ok = avs_write_i && avs_byteenable_i[0] && state == ST_RUN;
   assign des1 = pin1_function_setting[DES_MSB:0];
   assign des2 = pin2_function_setting[DES_MSB:0];
   assign gpio1 = des1 == DES_GPIO;
   assign gpio2 = des2 == DES_GPIO;

   always_comb begin
      next_state = ST_RUN;
      next_pin1 = pin1_function_setting;
      next_pin2 = pin2_function_setting;
      unique case (state)
         ST_LOAD: begin
            // Working copy taken from the stored one once after reset
            next_pin1 = store_pin1_i & SET_MASK; // RULE7
            next_pin2 = store_pin2_i & SET_MASK; // RULE7
         end
         ST_RUN: begin
            if (wr_ok && avs_address_i == OFS_PIN1) begin
               next_pin1 = avs_writedata_i[7:0] & SET_MASK; // RULE8
            end
            if (wr_ok && avs_address_i == OFS_PIN2) begin
               next_pin2 = avs_writedata_i[7:0] & SET_MASK; // RULE8
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_LOAD;
         pin1_function_setting <= PIN1_RESET;
         pin2_function_setting <= PIN2_RESET;
      end else begin
         state <= next_state;
         pin1_function_setting <= next_pin1;
         pin2_function_setting <= next_pin2;
      end
   end

   // Reads answer one cycle late; writes complete at once outside the load cycle
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (avs_address_i)
         OFS_PIN1: next_rdata[7:0] = pin1_function_setting;
         OFS_PIN2: next_rdata[7:0] = pin2_function_setting;
         OFS_STORE1: next_rdata[7:0] = store_pin1_i;
         OFS_STORE2: next_rdata[7:0] = store_pin2_i;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_done <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         rd_done <= avs_read_i && !rd_done;
         avs_readdata_o <= next_rdata;
      end
   end

   // Writes wait out the load cycle so they are not overwritten
   assign avs_waitrequest_o = (avs_read_i && !rd_done) || (avs_write_i && state == ST_LOAD);

   // Stored copy updated by software; it only matters after the next power-up
   assign store_wdata_o = avs_writedata_i[7:0] & SET_MASK;
   assign store_we1_o = wr_ok && avs_address_i == OFS_STORE1;
   assign store_we2_o = wr_ok && avs_address_i == OFS_STORE2;
   assign loaded_o = state == ST_RUN;

   // Pin 1 mux; reserved codes leave the pin undriven
   always_comb begin
      pin1_out_o = 1'b0;
      pin1_oe_o = 1'b0;
      unique case (des1)
         DES_GPIO: begin
            pin1_out_o = pin1_function_setting[LEVEL_BIT]; // RULE4 RULE6
            pin1_oe_o = !pin1_function_setting[DIR_BIT]; // RULE5 RULE6
         end
         DES_DEDICATED: begin
            pin1_out_o = ref_clock_i; // RULE2
            pin1_oe_o = 1'b1;
         end
         DES_ALT0: pin1_oe_o = 1'b0; // RULE2
         DES_ALT1: begin
            pin1_out_o = uart_tx_activity_led_i; // RULE1
            pin1_oe_o = 1'b1;
         end
         DES_ALT2: pin1_oe_o = 1'b0; // RULE1
         default: pin1_oe_o = 1'b0; // RULE3
      endcase
   end

   assign irq_edge_in_o = (des1 == DES_ALT2) ? pin1_in_i : 1'b0; // RULE1
   assign analog_input_ch1_o = (des1 == DES_ALT0) ? pin1_in_i : 1'b0; // RULE2

   // Pin 2 mux; functional units are outside, reached by plain inputs
   always_comb begin
      pin2_out_o = 1'b0;
      pin2_oe_o = 1'b0;
      unique case (des2)
         DES_GPIO: begin
            pin2_out_o = pin2_function_setting[LEVEL_BIT]; // RULE4 RULE6
            pin2_oe_o = !pin2_function_setting[DIR_BIT]; // RULE5 RULE6
         end
         DES_DEDICATED: begin
            pin2_out_o = pin2_dedicated_i;
            pin2_oe_o = 1'b1;
         end
         DES_ALT0: begin
            pin2_out_o = pin2_alt0_i;
            pin2_oe_o = 1'b1;
         end
         DES_ALT1: begin
            pin2_out_o = pin2_alt1_i;
            pin2_oe_o = 1'b1;
         end
         default: pin2_oe_o = 1'b0;
      endcase
   end

   assign analog_pin2_o = 1'b0;
   assign gpio_in_o = {gpio2 ? pin2_in_i : 1'b0, gpio1 ? pin1_in_i : 1'b0};

   a_gpio_level_drive: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE4
      gpio1 && !pin1_function_setting[DIR_BIT] |-> pin1_oe_o
         && pin1_out_o == pin1_function_setting[LEVEL_BIT])
      else $error("pin 1 gpio output level wrong");
   a_gpio_dir_input: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE5
      gpio2 && pin2_function_setting[DIR_BIT] |-> !pin2_oe_o)
      else $error("pin 2 gpio input still driven");
   a_led_route_pin1: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE1
      des1 == DES_ALT1 |-> pin1_oe_o && pin1_out_o == uart_tx_activity_led_i)
      else $error("pin 1 led route wrong");
   a_irq_route_pin1: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE1
      des1 == DES_ALT2 |-> !pin1_oe_o && irq_edge_in_o == pin1_in_i)
      else $error("pin 1 interrupt route wrong");
   a_clock_route_pin1: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE2
      des1 == DES_DEDICATED |-> pin1_oe_o && pin1_out_o == ref_clock_i)
      else $error("pin 1 clock route wrong");
   a_analog_route_pin1: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE2
      des1 == DES_ALT0 |-> !pin1_oe_o && analog_input_ch1_o == pin1_in_i)
      else $error("pin 1 analog route wrong");
   a_reserved_code_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE3
      des1 > DES_ALT2 |-> !pin1_oe_o)
      else $error("reserved code drives pin 1");
   a_write_takes_effect: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE7
      wr_ok && avs_address_i == OFS_PIN1 |=> pin1_function_setting
         == ($past(avs_writedata_i[7:0]) & SET_MASK))
      else $error("pin 1 setting write lost");
   a_load_from_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE7
      state == ST_LOAD |=> state == ST_RUN && pin2_function_setting
         == ($past(store_pin2_i) & SET_MASK))
      else $error("stored setting not loaded");
   a_reserved_bits_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE8
      state == ST_RUN |-> (pin1_function_setting & ~SET_MASK) == 8'h00)
      else $error("reserved setting bits kept");
   a_pin2_gpio_drive: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE4
      gpio2 && !pin2_function_setting[DIR_BIT] |-> pin2_oe_o
         && pin2_out_o == pin2_function_setting[LEVEL_BIT])
      else $error("pin 2 gpio output level wrong");
   a_pin1_dir_input: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE5
      gpio1 && pin1_function_setting[DIR_BIT] |-> !pin1_oe_o)
      else $error("pin 1 gpio input still driven");
   a_pin2_write_effect: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE7
      wr_ok && avs_address_i == OFS_PIN2 |=> pin2_function_setting
         == ($past(avs_writedata_i[7:0]) & SET_MASK))
      else $error("pin 2 setting write lost");

   // Read answer carries the setting seen in the cycle the read was asked
   sequence s_pin1_read_asked;
      avs_read_i && avs_waitrequest_o && avs_address_i == OFS_PIN1;
   endsequence
   sequence s_read_answered;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   a_read_data_pin1: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE7
      s_pin1_read_asked ##1 s_read_answered |-> avs_readdata_o
         == {24'h00_0000, $past(pin1_function_setting)})
      else $error("pin 1 setting read back wrong");
endmodule : gpd_pin_config

// ==== hw/gpd_pkg.sv ====
// Constants for the general pin designation block
// How it works
// [RULE1] Pin 1 code 100 routes the pin to the interrupt edge detector and 011 to the UART transmit activity LED, the default.
// [RULE2] Pin 1 code 010 routes the pin to analog input channel 1 and 001 to the reference clock output.
// [RULE3] Pin 1 codes 111, 110 and 101 are reserved; software must not write them and the pin then gets no function.
// [RULE4] Bit 4 is the level a GPIO output drives, high by default.
// [RULE5] Bit 3 selects GPIO direction, 1 input and 0 output by default, honoured only in GPIO mode.
// [RULE6] Code 000 makes the pin a plain GPIO governed by direction and level bits.
// [RULE7] Settings load from the stored copy at power-up, and any change to the working copy takes effect at once.
// [RULE8] Bits 7 to 5 are reserved, written as zero and ignored by the pin logic.
package gpd_pkg;
   localparam logic [3:0] OFS_PIN1 = 4'h0;
   localparam logic [3:0] OFS_PIN2 = 4'h4;
   localparam logic [3:0] OFS_STORE1 = 4'h8;
   localparam logic [3:0] OFS_STORE2 = 4'hC;
   localparam int LEVEL_BIT = 4;
   localparam int DIR_BIT = 3;
   localparam int DES_MSB = 2;
   localparam logic [7:0] PIN1_RESET = 8'h13;
   localparam logic [7:0] PIN2_RESET = 8'h11;
   localparam logic [7:0] SET_MASK = 8'h1F;
   localparam logic [2:0] DES_GPIO = 3'h0;
   localparam logic [2:0] DES_DEDICATED = 3'h1;
   localparam logic [2:0] DES_ALT0 = 3'h2;
   localparam logic [2:0] DES_ALT1 = 3'h3;
   localparam logic [2:0] DES_ALT2 = 3'h4;
   typedef enum logic [1:0] {ST_LOAD = 2'b00, ST_RUN = 2'b01} gpd_state_t;
endpackage : gpd_pkg

// ==== test/gp_pin_designation_config_tb.sv ====
// Self-checking bench for the general pin designation block
`timescale 1ns/1ns
module gp_pin_designation_config_tb;
   import gpd_pkg::*;
   logic ref_clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [3:0] avs_address_i, avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [7:0] store_pin1_i, store_pin2_i;
   logic ref_clock_i, uart_tx_activity_led_i, pin2_dedicated_i, pin2_alt0_i, pin2_alt1_i;
   logic pin1_in_i, pin2_in_i, pin1_out_o, pin1_oe_o, pin2_out_o, pin2_oe_o;
   logic irq_edge_in_o, analog_input_ch1_o;
   logic [1:0] gpio_in_o;
   logic analog_pin2_o, store_we1_o, store_we2_o, loaded_o;
   logic [7:0] store_wdata_o;
   wire logic [31:0] store_seen = {22'h00_0000, store_we2_o, store_we1_o, store_wdata_o};
   logic [31:0] exp_q[$];
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   gpd_pin_config dut (.ref_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .store_pin1_i,
      .store_pin2_i, .ref_clock_i, .uart_tx_activity_led_i, .pin2_dedicated_i, .pin2_alt0_i,
      .pin2_alt1_i, .pin1_in_i, .pin2_in_i, .pin1_out_o, .pin1_oe_o, .pin2_out_o, .pin2_oe_o,
      .irq_edge_in_o, .analog_input_ch1_o, .analog_pin2_o, .gpio_in_o, .store_wdata_o,
      .store_we1_o, .store_we2_o, .loaded_o);
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      if (err_total == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         final_report();
      end
   end
   // Answers are taken at the very edge that sees waitrequest low
   always @(posedge ref_clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         check(avs_readdata_o, exp_q.pop_front());
      end
      if (avs_write_i && avs_waitrequest_o === 1'b0 && avs_address_i[3]) begin
         check(store_seen, exp_q.pop_front());
      end
   end
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
      input logic [3:0] be, input logic [7:0] exp);
      logic [1:0] we;
      we = {be[0] && a == OFS_STORE2, be[0] && a == OFS_STORE1};
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_writedata_i <= {24'h00_0000, d};
      avs_byteenable_i <= be;
      if (!wr) begin
         exp_q.push_back({24'h00_0000, exp});
      end else if (a[3]) begin
         exp_q.push_back({22'h00_0000, we, d & SET_MASK});
      end
      // No cycle count assumed; only the bench ceiling ends this wait
      do begin
         @(posedge ref_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // Idle edge so a following call never re-raises a strobe in the same step
      @(posedge ref_clk_i);
   endtask : bus
   task automatic pins(input logic [7:0] s1, input logic [7:0] s2);
      logic [3:0] e1;
      logic [1:0] e2;
      logic [1:0] eg;
      @(negedge ref_clk_i);
      case (s1[2:0])
         3'h0: e1 = {~s1[3], s1[4] & ~s1[3], 2'h0};
         3'h1: e1 = {1'h1, ref_clock_i, 2'h0};
         3'h2: e1 = {3'h0, pin1_in_i};
         3'h3: e1 = {1'h1, uart_tx_activity_led_i, 2'h0};
         3'h4: e1 = {2'h0, pin1_in_i, 1'h0};
         default: e1 = 4'h0;
      endcase
      check({28'h000_0000, pin1_oe_o, pin1_out_o & pin1_oe_o, irq_edge_in_o,
         analog_input_ch1_o}, {28'h000_0000, e1});
      eg = {s2[2:0] == 3'h0 && pin2_in_i, s1[2:0] == 3'h0 && pin1_in_i};
      check({29'h0, analog_pin2_o, gpio_in_o}, {29'h0, 1'b0, eg});
      case (s2[2:0])
         3'h0: e2 = {~s2[3], s2[4] & ~s2[3]};
         3'h1: e2 = {1'h1, pin2_dedicated_i};
         3'h2: e2 = {1'h1, pin2_alt0_i};
         3'h3: e2 = {1'h1, pin2_alt1_i};
         default: e2 = 2'h0;
      endcase
      check({30'h0, pin2_oe_o, pin2_out_o & pin2_oe_o}, {30'h0, e2});
      @(posedge ref_clk_i);
   endtask : pins
   // Ends one edge after release, so the first request misses the load cycle
   task automatic restart(input logic [7:0] p1, input logic [7:0] p2, input int len);
      store_pin1_i <= p1;
      store_pin2_i <= p2;
      nrst_i <= 1'b0;
      repeat (len) @(posedge ref_clk_i);
      check({29'h0, loaded_o, pin1_oe_o, pin2_oe_o}, 32'h0000_0003);
      nrst_i <= 1'b1;
      @(posedge ref_clk_i);
   endtask : restart
   initial begin
      logic [7:0] s1, s2;
      void'($urandom(52));
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0000_0000;
      avs_byteenable_i = 4'h0;
      {ref_clock_i, uart_tx_activity_led_i, pin2_dedicated_i, pin2_alt0_i} = 4'h0;
      {pin2_alt1_i, pin1_in_i, pin2_in_i} = 3'h0;
      restart(8'($urandom), 8'($urandom), 10);
      bus(1'b0, OFS_PIN1, 8'h00, 4'h1, store_pin1_i & SET_MASK);
      check({31'h0, loaded_o}, 32'h0000_0001);
      bus(1'b0, OFS_PIN2, 8'h00, 4'h1, store_pin2_i & SET_MASK);
      bus(1'b0, OFS_STORE2, 8'h00, 4'h1, store_pin2_i);
      // Lane zero disabled, so the write must be dropped
      bus(1'b1, OFS_PIN1, 8'h1C, 4'hE, 8'h00);
      bus(1'b0, OFS_PIN1, 8'h00, 4'h1, store_pin1_i & SET_MASK);
      bus(1'b0, 4'h1, 8'h00, 4'h1, 8'h00);
      for (int i = 0; i < 32; i++) begin
         s1 = {3'h0, 1'($urandom), i[3], 3'(i % 5)};
         s2 = {3'h0, 2'($urandom), 3'(i % 4)};
         {ref_clock_i, uart_tx_activity_led_i, pin2_dedicated_i, pin1_in_i} <= 4'($urandom);
         {pin2_alt0_i, pin2_alt1_i, pin2_in_i} <= 3'($urandom);
         bus(1'b1, OFS_PIN1, s1, 4'h1, 8'h00);
         bus(1'b1, OFS_PIN2, s2, 4'hF, 8'h00);
         pins(s1, s2);
         // Stored copy written; the pin 1 working copy must stay as it was
         bus(1'b1, i[0] ? OFS_STORE2 : OFS_STORE1, s2, 4'h1, 8'h00);
         bus(1'b0, OFS_PIN1, 8'h00, 4'h1, s1 & SET_MASK);
      end
      // Second power-up from a stored byte with reserved bits and a reserved code
      restart(8'hE6, 8'($urandom), 3);
      bus(1'b0, OFS_PIN1, 8'h00, 4'h1, 8'h06);
      bus(1'b0, OFS_PIN2, 8'h00, 4'h1, store_pin2_i & SET_MASK);
      pins(8'h06, store_pin2_i & SET_MASK);
      final_report();
   end
endmodule : gp_pin_designation_config_tb
